// File: logic/cad_pkg.sv
// Constants, register map and operation codes of the core arithmetic engine.
// Assumes one core clock shared with the decoder and the working register file.
package cad_pkg;

	// Register port indexes
	localparam logic [3:0] REG_CORE_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h1;
	localparam logic [3:0] REG_ACC0_LO   = 4'h2;
	localparam logic [3:0] REG_ACC0_MID  = 4'h3;
	localparam logic [3:0] REG_ACC0_HI   = 4'h4;
	localparam logic [3:0] REG_ACC1_LO   = 4'h5;
	localparam logic [3:0] REG_ACC1_MID  = 4'h6;
	localparam logic [3:0] REG_ACC1_HI   = 4'h7;

	// Core control fields and reset
	localparam int unsigned CC_MUL_MODE = 0;
	localparam int unsigned CC_ROUND    = 1;
	localparam int unsigned CC_FRAME    = 2;
	localparam int unsigned CC_SATMODE  = 4;
	localparam int unsigned CC_SATWR    = 5;
	localparam int unsigned CC_SAT_B    = 6;
	localparam int unsigned CC_SAT_A    = 7;
	localparam int unsigned CC_SIGN_LO  = 12;
	localparam logic [15:0] CORE_CTRL_RESET = 16'h0000;
	localparam logic [15:0] CORE_CTRL_WMASK = 16'h30F3;

	// Multiply sign selections
	localparam logic [1:0] SGN_SIGNED   = 2'h0;
	localparam logic [1:0] SGN_UNSIGNED = 2'h1;

	// Status word fields and reset
	localparam int unsigned SW_C  = 0;
	localparam int unsigned SW_Z  = 1;
	localparam int unsigned SW_V  = 2;
	localparam int unsigned SW_N  = 3;
	localparam int unsigned SW_NB = 8;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// Divider length and accumulator limits
	localparam logic [4:0]  DIV_LAST      = 5'h0F;
	localparam logic [39:0] ACC_RESET     = 40'h0000000000;
	localparam logic [39:0] ACC_MAX_NORM  = 40'h007FFFFFFF;
	localparam logic [39:0] ACC_MIN_NORM  = 40'hFF80000000;
	localparam logic [39:0] ACC_MAX_SUPER = 40'h7FFFFFFFFF;
	localparam logic [39:0] ACC_MIN_SUPER = 40'h8000000000;
	localparam logic [39:0] ROUND_HALF    = 40'h0000008000;

	// Operations issued by the decoder
	typedef enum logic [4:0] {
		OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
		OP_SHL, OP_LSR, OP_ASR,
		OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_UXS, OP_MUL_SLIT, OP_MUL_ULIT,
		OP_MUL_BYTE, OP_DIV_S, OP_DIV_U,
		ACCUMULATOR_ZERO_OP, SQUARE_OF_DIFF_OP, ACCUM_SQUARE_OF_DIFF_OP,
		MULTIPLY_ACCUM_OP, STORE_ACCUM_OP, MULTIPLY_ONLY_OP, NEGATED_MULTIPLY_OP,
		MULTIPLY_SUBTRACT_OP, OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG, OP_ACC_SHIFT
	} cad_op_type;

endpackage

// File: logic/cad_engine.sv
// Arithmetic datapath: 16-bit ALU, 17x17 multiplier, iterative divider, DSP engine.
// Assumes the decoder fetches operands and writes results back on the same clock.
`timescale 1ns/1ps

// Function
// - ALU is 16 bits wide: add, subtract, shifts, logic operations.
// - Arithmetic results use two's complement unless stated otherwise.
// - Add and subtract update carry, zero, negative, overflow and digit-carry flags; logic ops and shifts update only zero and negative.
// - On subtraction carry and digit carry mean no borrow.
// - Byte or word operation selected by the instruction mode.
// - Operands from registers or memory; result goes to registers or memory.
// - 17x17 multiplier handles unsigned, signed and mixed-sign products.
// - Integer modes: signed, unsigned, mixed, 16x5 literal, 8x8 unsigned.
// - Signed and unsigned divide, 32/16 and 16/16.
// - Quotient goes to working register zero, remainder to register one.
// - Divisor any register; 32-bit dividend from aligned pair, odd word high.
// - Divide takes one cycle per divisor bit for both sizes.
// - 40-bit shifter and adder feed two accumulators with round and saturate.
// - Accumulator add, subtract and negate need no other operand.
// - Control bits pick multiply sign, saturation per target, saturation mode.
// - Rounding select 1 means biased rounding, 0 means convergent.
// - Multiply mode bit 1 means integer, 0 means fractional.
// - Stack frame active makes frame and stack pointers unpaged.
// - Accumulator ops: clear, squared difference, multiply-accumulate, negate, store.
module cad_engine (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	// Operation request
	input  wire logic                 op_valid,
	input  wire cad_pkg::cad_op_type  op_code,
	input  wire logic                 op_byte,
	input  wire logic                 op_long,
	input  wire logic                 op_acc_b,
	input  wire logic                 op_dest_mem,
	input  wire logic [3:0]           op_dest_idx,
	input  wire logic [15:0]          op_a,
	input  wire logic [15:0]          op_b,
	input  wire logic [15:0]          op_c,
	input  wire logic                 stack_frame_in,
	// Results and status
	output logic                      op_ready_q,
	output logic                      res_valid_q,
	output logic                      res_to_mem_q,
	output logic [3:0]                res_lo_idx_q,
	output logic [15:0]               res_lo_q,
	output logic                      res_hi_valid_q,
	output logic [3:0]                res_hi_idx_q,
	output logic [15:0]               res_hi_q,
	output logic [15:0]               status_word_q,
	output logic                      frame_unpaged_q,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [15:0]               reg_rdata_q
);
	import cad_pkg::*;

	logic [15:0] core_ctrl_q;
	logic [39:0] acc_q [2];
	logic [4:0]  div_cnt_q;
	logic [15:0] div_rem_q;
	logic [15:0] div_quo_q;
	logic [15:0] div_dvs_q;
	logic        div_qneg_q;
	logic        div_rneg_q;

	logic        fire;
	logic        fire_div;
	logic        alu_op;
	logic        mul_op;
	logic        dsp_wr;
	logic        div_signed;
	logic        is_sub;
	logic        cin;
	logic [15:0] b_eff;
	logic [16:0] sum_w;
	logic [8:0]  sum_b;
	logic [4:0]  sum_n;
	logic [15:0] alu_r;
	logic [15:0] alu_res;
	logic        alu_arith;
	logic [16:0] mx;
	logic [16:0] my;
	logic [16:0] diff;
	logic signed [33:0] mprod;
	logic [39:0] prod40;
	logic [39:0] acc_t;
	logic [39:0] acc_o;
	logic [39:0] acc_sh;
	logic [5:0]  sh_left;
	logic [40:0] dsum;
	logic [39:0] dsat;
	logic [39:0] acc_rnd;
	logic [15:0] store_word;
	logic [31:0] dvd;
	logic [31:0] dvd_mag;
	logic [15:0] dvs_mag;
	logic [17:0] trial;
	logic [16:0] shifted;
	logic [15:0] rem_nx;
	logic [15:0] quo_nx;
	logic [15:0] cc_view;

	// Request handshake
	assign fire     = op_valid && op_ready_q;
	assign fire_div = fire && (op_code inside {OP_DIV_S, OP_DIV_U});
	assign alu_op   = op_code inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR,
		OP_XOR, OP_SHL, OP_LSR, OP_ASR};
	assign mul_op   = op_code inside {OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_UXS,
		OP_MUL_SLIT, OP_MUL_ULIT, OP_MUL_BYTE};

	// Two's complement adder with inverted-borrow carry
	always_comb begin
		is_sub = (op_code == OP_SUB) || (op_code == OP_SUBB);
		b_eff  = is_sub ? ~op_b : op_b;
		case (op_code)
			OP_ADDC, OP_SUBB: cin = status_word_q[SW_C];
			OP_SUB:           cin = 1'b1;
			default:          cin = 1'b0;
		endcase
		sum_w = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, cin};
		sum_b = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
		sum_n = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	end

	// ALU result select
	always_comb begin
		alu_arith = 1'b0;
		case (op_code)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
				alu_arith = 1'b1;
				alu_r     = sum_w[15:0];
			end
			OP_AND:  alu_r = op_a & op_b;
			OP_IOR:  alu_r = op_a | op_b;
			OP_XOR:  alu_r = op_a ^ op_b;
			OP_SHL:  alu_r = op_byte ? {8'h00, 8'(op_a[7:0] << op_b[3:0])} : op_a << op_b[3:0];
			OP_LSR:  alu_r = op_byte ? {8'h00, 8'(op_a[7:0] >> op_b[3:0])} : op_a >> op_b[3:0];
			OP_ASR:  alu_r = op_byte ? {8'h00, 8'($signed(op_a[7:0]) >>> op_b[3:0])}
				: 16'($signed(op_a) >>> op_b[3:0]);
			default: alu_r = op_a;
		endcase
		alu_res = op_byte ? {op_a[15:8], alu_r[7:0]} : alu_r;
	end

	// Multiplier operand extension
	always_comb begin
		diff = {op_a[15], op_a} - {op_b[15], op_b};
		mx   = {op_a[15], op_a};
		my   = {op_b[15], op_b};
		case (op_code)
			OP_MUL_UU: begin
				mx = {1'b0, op_a};
				my = {1'b0, op_b};
			end
			OP_MUL_SU:   my = {1'b0, op_b};
			OP_MUL_UXS:  mx = {1'b0, op_a};
			OP_MUL_SLIT: my = {12'h000, op_b[4:0]};
			OP_MUL_ULIT: begin
				mx = {1'b0, op_a};
				my = {12'h000, op_b[4:0]};
			end
			OP_MUL_BYTE: begin
				mx = {9'h000, op_a[7:0]};
				my = {9'h000, op_b[7:0]};
			end
			SQUARE_OF_DIFF_OP, ACCUM_SQUARE_OF_DIFF_OP: begin
				mx = diff;
				my = diff;
			end
			OP_MUL_SS: mx = {op_a[15], op_a};
			default: begin
				if (core_ctrl_q[CC_SIGN_LO+:2] == SGN_UNSIGNED) begin
					mx = {1'b0, op_a};
					my = {1'b0, op_b};
				end else if (core_ctrl_q[CC_SIGN_LO+:2] != SGN_SIGNED) begin
					my = {1'b0, op_b};
				end
			end
		endcase
		mprod = $signed(mx) * $signed(my);
		if (core_ctrl_q[CC_MUL_MODE])
			prod40 = {{6{mprod[33]}}, mprod};
		else
			prod40 = {{5{mprod[33]}}, mprod, 1'b0};
	end

	// Accumulator adder, barrel shifter and saturation
	always_comb begin
		acc_t   = op_acc_b ? acc_q[1] : acc_q[0];
		acc_o   = op_acc_b ? acc_q[0] : acc_q[1];
		sh_left = 6'(-op_b[5:0]);
		acc_sh  = op_b[5] ? 40'(acc_t << sh_left) : 40'($signed(acc_t) >>> op_b[5:0]);
		dsp_wr  = 1'b1;
		case (op_code)
			ACCUMULATOR_ZERO_OP:  dsum = 41'h00000000000;
			SQUARE_OF_DIFF_OP, MULTIPLY_ONLY_OP: dsum = {prod40[39], prod40};
			ACCUM_SQUARE_OF_DIFF_OP, MULTIPLY_ACCUM_OP:
				dsum = {acc_t[39], acc_t} + {prod40[39], prod40};
			NEGATED_MULTIPLY_OP:  dsum = 41'h00000000000 - {prod40[39], prod40};
			MULTIPLY_SUBTRACT_OP: dsum = {acc_t[39], acc_t} - {prod40[39], prod40};
			OP_ACC_ADD:           dsum = {acc_t[39], acc_t} + {acc_o[39], acc_o};
			OP_ACC_SUB:           dsum = {acc_t[39], acc_t} - {acc_o[39], acc_o};
			OP_ACC_NEG:           dsum = 41'h00000000000 - {acc_t[39], acc_t};
			OP_ACC_SHIFT:         dsum = {acc_sh[39], acc_sh};
			default: begin
				dsum   = {acc_t[39], acc_t};
				dsp_wr = 1'b0;
			end
		endcase
		dsat = dsum[39:0];
		if (op_acc_b ? core_ctrl_q[CC_SAT_B] : core_ctrl_q[CC_SAT_A]) begin
			if (core_ctrl_q[CC_SATMODE]) begin
				if (dsum[40] != dsum[39])
					dsat = dsum[40] ? ACC_MIN_SUPER : ACC_MAX_SUPER;
			end else if (dsum[40:31] != {10{dsum[40]}}) begin
				dsat = dsum[40] ? ACC_MIN_NORM : ACC_MAX_NORM;
			end
		end
	end

	// Rounded, optionally saturated store word
	always_comb begin
		if (core_ctrl_q[CC_ROUND] || acc_t[15:0] != 16'h8000 || acc_t[16])
			acc_rnd = acc_t + ROUND_HALF;
		else
			acc_rnd = acc_t;
		store_word = acc_rnd[31:16];
		if (core_ctrl_q[CC_SATWR] && acc_rnd[39:31] != {9{acc_rnd[39]}})
			store_word = acc_rnd[39] ? 16'h8000 : 16'h7FFF;
	end

	// Divider operand magnitudes and one restoring step
	always_comb begin
		div_signed = (op_code == OP_DIV_S);
		if (op_long)
			dvd = {op_c, op_a};
		else
			dvd = {(div_signed ? {16{op_a[15]}} : 16'h0000), op_a};
		dvd_mag = (div_signed && dvd[31]) ? 32'(-dvd) : dvd;
		dvs_mag = (div_signed && op_b[15]) ? 16'(-op_b) : op_b;
		shifted = {div_rem_q, div_quo_q[15]};
		trial   = {1'b0, shifted} - {2'h0, div_dvs_q};
		rem_nx  = trial[17] ? shifted[15:0] : trial[15:0];
		quo_nx  = {div_quo_q[14:0], ~trial[17]};
	end

	// Divider sequence, one step per divisor bit
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			op_ready_q <= 1'b1;
			div_cnt_q  <= 5'h00;
			div_rem_q  <= 16'h0000;
			div_quo_q  <= 16'h0000;
			div_dvs_q  <= 16'h0000;
			div_qneg_q <= 1'b0;
			div_rneg_q <= 1'b0;
		end else if (fire_div) begin
			op_ready_q <= 1'b0;
			div_cnt_q  <= 5'h00;
			div_rem_q  <= dvd_mag[31:16];
			div_quo_q  <= dvd_mag[15:0];
			div_dvs_q  <= dvs_mag;
			div_qneg_q <= div_signed && (dvd[31] ^ op_b[15]);
			div_rneg_q <= div_signed && dvd[31];
		end else if (!op_ready_q) begin
			div_cnt_q  <= 5'(div_cnt_q + 5'h01);
			div_rem_q  <= rem_nx;
			div_quo_q  <= quo_nx;
			op_ready_q <= (div_cnt_q == DIV_LAST);
		end
	end

	// Result write-back
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			res_valid_q    <= 1'b0;
			res_to_mem_q   <= 1'b0;
			res_lo_idx_q   <= 4'h0;
			res_lo_q       <= 16'h0000;
			res_hi_valid_q <= 1'b0;
			res_hi_idx_q   <= 4'h0;
			res_hi_q       <= 16'h0000;
		end else if (!op_ready_q && div_cnt_q == DIV_LAST) begin
			res_valid_q    <= 1'b1;
			res_to_mem_q   <= 1'b0;
			res_lo_idx_q   <= 4'h0;
			res_lo_q       <= div_qneg_q ? 16'(-quo_nx) : quo_nx;
			res_hi_valid_q <= 1'b1;
			res_hi_idx_q   <= 4'h1;
			res_hi_q       <= div_rneg_q ? 16'(-rem_nx) : rem_nx;
		end else if (fire && (alu_op || mul_op || op_code == STORE_ACCUM_OP)) begin
			res_valid_q    <= 1'b1;
			res_to_mem_q   <= op_dest_mem;
			res_lo_idx_q   <= op_dest_idx;
			res_hi_idx_q   <= 4'(op_dest_idx + 4'h1);
			res_hi_valid_q <= mul_op && (op_code != OP_MUL_BYTE);
			res_hi_q       <= mprod[31:16];
			if (alu_op)
				res_lo_q <= alu_res;
			else if (mul_op)
				res_lo_q <= mprod[15:0];
			else
				res_lo_q <= store_word;
		end else begin
			res_valid_q    <= 1'b0;
			res_hi_valid_q <= 1'b0;
		end
	end

	// Status flags
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_word_q <= STATUS_RESET;
		end else if (fire && alu_op) begin
			status_word_q[SW_Z] <= op_byte ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0000);
			status_word_q[SW_N] <= op_byte ? alu_r[7] : alu_r[15];
			if (alu_arith) begin
				status_word_q[SW_C]  <= op_byte ? sum_b[8] : sum_w[16];
				status_word_q[SW_NB] <= sum_n[4];
				status_word_q[SW_V]  <= op_byte
					? (op_a[7] == b_eff[7]) && (alu_r[7] != op_a[7])
					: (op_a[15] == b_eff[15]) && (alu_r[15] != op_a[15]);
			end
		end
	end

	// Two accumulators
	for (genvar g = 0; g < 2; g++) begin : g_acc
		always_ff @(posedge ref_clk) begin
			if (reset)
				acc_q[g] <= ACC_RESET;
			else if (fire && dsp_wr && (op_acc_b == 1'(g)))
				acc_q[g] <= dsat;
		end
	end

	// Core control and stack frame status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			core_ctrl_q     <= CORE_CTRL_RESET;
			frame_unpaged_q <= 1'b0;
		end else begin
			frame_unpaged_q <= stack_frame_in;
			if (reg_wr && reg_addr == REG_CORE_CTRL)
				core_ctrl_q <= reg_wdata & CORE_CTRL_WMASK;
		end
	end

	// Register reads, data valid one cycle after the strobe
	always_comb begin
		cc_view         = core_ctrl_q;
		cc_view[CC_FRAME] = frame_unpaged_q;
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !reg_rd) begin
			reg_rdata_q <= 16'h0000;
		end else begin
			case (reg_addr)
				REG_CORE_CTRL: reg_rdata_q <= cc_view;
				REG_STATUS:    reg_rdata_q <= status_word_q;
				REG_ACC0_LO:   reg_rdata_q <= acc_q[0][15:0];
				REG_ACC0_MID:  reg_rdata_q <= acc_q[0][31:16];
				REG_ACC0_HI:   reg_rdata_q <= {8'h00, acc_q[0][39:32]};
				REG_ACC1_LO:   reg_rdata_q <= acc_q[1][15:0];
				REG_ACC1_MID:  reg_rdata_q <= acc_q[1][31:16];
				REG_ACC1_HI:   reg_rdata_q <= {8'h00, acc_q[1][39:32]};
				default:       reg_rdata_q <= 16'h0000;
			endcase
		end
	end

	// Checks
	property p_sub_borrow;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == OP_SUB && !op_byte |=>
			status_word_q[SW_C] == ($past(op_a) >= $past(op_b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("carry not inverted borrow");

	property p_xor_zero;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == OP_XOR && op_a == op_b |=> status_word_q[SW_Z] && !status_word_q[SW_N];
	endproperty
	a_xor_zero: assert property (p_xor_zero) else $error("zero flag wrong");

	property p_byte_keep;
		@(posedge ref_clk) disable iff (reset)
		fire && op_byte && op_code == OP_ADD |=> res_valid_q && res_lo_q[15:8] == $past(op_a[15:8]);
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("byte op touched upper byte");

	property p_mul_uu;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == OP_MUL_UU |=> {res_hi_q, res_lo_q} == 32'($past(op_a)) * 32'($past(op_b));
	endproperty
	a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong");

	property p_div_time;
		@(posedge ref_clk) disable iff (reset)
		fire_div |=> (!res_valid_q [*8]) ##8 (!res_valid_q && !op_ready_q) ##1 (res_valid_q && op_ready_q);
	endproperty
	a_div_time: assert property (p_div_time) else $error("divide length wrong");

	property p_div_regs;
		@(posedge ref_clk) disable iff (reset)
		fire_div |-> ##17 (res_lo_idx_q == 4'h0 && res_hi_idx_q == 4'h1 && res_hi_valid_q);
	endproperty
	a_div_regs: assert property (p_div_regs) else $error("divide targets wrong");

	property p_div_quot;
		@(posedge ref_clk) disable iff (reset)
		fire_div && op_code == OP_DIV_U && !op_long && op_b != 16'h0000 |-> ##17
			res_lo_q == $past(op_a, 17) / $past(op_b, 17) && res_hi_q == $past(op_a, 17) % $past(op_b, 17);
	endproperty
	a_div_quot: assert property (p_div_quot) else $error("quotient or remainder wrong");

	property p_acc_zero;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == ACCUMULATOR_ZERO_OP && !op_acc_b |=> acc_q[0] == ACC_RESET;
	endproperty
	a_acc_zero: assert property (p_acc_zero) else $error("clear left accumulator set");

	property p_acc_neg;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == OP_ACC_NEG && !op_acc_b && !core_ctrl_q[CC_SAT_A] |=>
			acc_q[0] == 40'(-$past(acc_q[0]));
	endproperty
	a_acc_neg: assert property (p_acc_neg) else $error("negate wrong");

	property p_int_mpy;
		@(posedge ref_clk) disable iff (reset)
		fire && op_code == MULTIPLY_ONLY_OP && !op_acc_b && core_ctrl_q[CC_MUL_MODE]
			&& core_ctrl_q[CC_SIGN_LO+:2] == SGN_SIGNED && !core_ctrl_q[CC_SAT_A] |=>
			acc_q[0] == 40'($signed($past(op_a)) * $signed($past(op_b)));
	endproperty
	a_int_mpy: assert property (p_int_mpy) else $error("integer multiply wrong");

	property p_frame;
		@(posedge ref_clk) disable iff (reset)
		##1 frame_unpaged_q == $past(stack_frame_in);
	endproperty
	a_frame: assert property (p_frame) else $error("stack frame status stale");

endmodule

// File: test/cad_regfile.sv
// Working register file and data memory word facing the engine result port.
// Assumes one-cycle result strobes on the shared core clock.
`timescale 1ns/1ps
module cad_regfile (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Result writes
	input  wire logic        res_valid_q,
	input  wire logic        res_to_mem_q,
	input  wire logic [3:0]  res_lo_idx_q,
	input  wire logic [15:0] res_lo_q,
	input  wire logic        res_hi_valid_q,
	input  wire logic [3:0]  res_hi_idx_q,
	input  wire logic [15:0] res_hi_q
);
	logic [15:0] wreg_q [16];
	logic [15:0] mem_q;
	// Write-back of low and high result words
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				wreg_q[i] <= 16'h0000;
			end
			mem_q <= 16'h0000;
		end else begin
			if (res_valid_q && res_to_mem_q) mem_q <= res_lo_q;
			if (res_valid_q && !res_to_mem_q) wreg_q[res_lo_idx_q] <= res_lo_q;
			if (res_hi_valid_q) wreg_q[res_hi_idx_q] <= res_hi_q;
		end
	end
endmodule

// File: test/test_cad_engine.sv
// Self-checking bench: ALU, multiplier, divider and DSP engine of the core.
// Assumes the bench acts as decoder and the register file model takes results.
`timescale 1ns/1ps
module test_cad_engine;
	import cad_pkg::*;
	logic        ref_clk, reset, op_valid, op_byte, op_long, op_acc_b, op_dest_mem;
	logic        stack_frame_in, reg_wr, reg_rd, op_ready_q, res_valid_q, res_to_mem_q;
	logic        res_hi_valid_q, frame_unpaged_q;
	cad_op_type  op_code, c;
	logic [3:0]  op_dest_idx, reg_addr, res_lo_idx_q, res_hi_idx_q;
	logic [15:0] op_a, op_b, op_c, reg_wdata, res_lo_q, res_hi_q, status_word_q, reg_rdata_q;
	logic [15:0] rv, ra, rb, oc, eq, er;
	logic [31:0] e32;
	logic [39:0] eb, e, p, acc;
	int          bad_count, samples_checked, seed, n, k;
	cad_engine u_cad_engine (.ref_clk, .reset, .op_valid, .op_code, .op_byte, .op_long,
		.op_acc_b, .op_dest_mem, .op_dest_idx, .op_a, .op_b, .op_c, .stack_frame_in,
		.op_ready_q, .res_valid_q, .res_to_mem_q, .res_lo_idx_q, .res_lo_q, .res_hi_valid_q,
		.res_hi_idx_q, .res_hi_q, .status_word_q, .frame_unpaged_q, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata_q);
	cad_regfile u_cad_regfile (.ref_clk, .reset, .res_valid_q, .res_to_mem_q, .res_lo_idx_q,
		.res_lo_q, .res_hi_valid_q, .res_hi_idx_q, .res_hi_q);
	// Core clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Compare and report
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Register port cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata_q;
	endtask
	task automatic rdacc(input logic b);
		logic [3:0] base;
		base = b ? REG_ACC1_LO : REG_ACC0_LO;
		rd(base);
		acc[15:0] = rv;
		rd(base + 4'h1);
		acc[31:16] = rv;
		rd(base + 4'h2);
		acc[39:32] = rv[7:0];
	endtask
	// One operation, sampled just after its acceptance edge
	task automatic issue(input cad_op_type o, input logic [15:0] a, input logic [15:0] b);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= o;
		op_a <= a;
		op_b <= b;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
	endtask
	// Expected add or subtract result with flags above it
	function automatic logic [31:0] alu_f(input logic sub, byt, input logic [15:0] a, b0);
		logic [15:0] b, st;
		logic [16:0] s;
		logic [8:0]  s8;
		logic [4:0]  nb;
		b = sub ? ~b0 : b0;
		s = a + b + sub;
		s8 = a[7:0] + b[7:0] + sub;
		nb = a[3:0] + b[3:0] + sub;
		st = 16'h0000;
		st[SW_NB] = nb[4];
		st[SW_C] = byt ? s8[8] : s[16];
		st[SW_N] = byt ? s8[7] : s[15];
		st[SW_Z] = byt ? (s8[7:0] == 8'h00) : (s[15:0] == 16'h0000);
		st[SW_V] = byt ? (a[7] == b[7]) && (s8[7] != a[7]) : (a[15] == b[15]) && (s[15] != a[15]);
		return byt ? {st, a[15:8], s8[7:0]} : {st, s[15:0]};
	endfunction
	// Expected logic or shift result with zero and negative flags above it
	function automatic logic [31:0] lgc_f(input int o, input logic y, input logic [15:0] a, b);
		logic [15:0] x, r, st;
		x = a;
		if (y) x[15:8] = (o == 5) ? {8{a[7]}} : 8'h00;
		case (o)
			0: r = a & b;
			1: r = a | b;
			2: r = a ^ b;
			3: r = x << b[3:0];
			4: r = x >> b[3:0];
			default: r = 16'($signed(x) >>> b[3:0]);
		endcase
		if (y) r[15:8] = a[15:8];
		st = 16'h0000;
		st[SW_Z] = y ? (r[7:0] == 8'h00) : (r == 16'h0000);
		st[SW_N] = y ? r[7] : r[15];
		return {st, r};
	endfunction
	// Expected integer product of each multiply mode
	function automatic logic [31:0] mul_f(input cad_op_type o, input logic [15:0] a, b);
		logic [31:0] xa, xb;
		xa = {(o inside {OP_MUL_SS, OP_MUL_SU, OP_MUL_SLIT}) ? {16{a[15]}} : 16'h0000, a};
		xb = {(o inside {OP_MUL_SS, OP_MUL_UXS}) ? {16{b[15]}} : 16'h0000, b};
		if (o inside {OP_MUL_SLIT, OP_MUL_ULIT}) xb = {27'h0000000, b[4:0]};
		if (o == OP_MUL_BYTE) xa = {24'h000000, a[7:0]};
		if (o == OP_MUL_BYTE) xb = {24'h000000, b[7:0]};
		return xa * xb;
	endfunction
	// Expected signed DSP product, fractional ones moved up one place
	function automatic logic [39:0] prod(input logic [15:0] x, y, input logic frac);
		logic [39:0] q;
		q = {{24{x[15]}}, x} * {{24{y[15]}}, y};
		return frac ? q << 1 : q;
	endfunction
	// Main sequence
	initial begin
		seed = 59;
		bad_count = 0;
		samples_checked = 0;
		reset = 1'b1;
		op_valid = 1'b0;
		op_code = OP_ADD;
		op_byte = 1'b0;
		op_long = 1'b0;
		op_acc_b = 1'b0;
		op_dest_mem = 1'b0;
		op_dest_idx = 4'h0;
		op_a = 16'h0000;
		op_b = 16'h0000;
		op_c = 16'h0000;
		stack_frame_in = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		for (n = 0; n < 9; n++) begin
			rd(4'(n));
			chk(rv, 40'h0); // RESET
		end
		chk(op_ready_q, 1'b1); // RESET
		wr(REG_STATUS, 16'hFFFF);
		wr(4'h9, 16'hFFFF);
		rd(REG_STATUS);
		chk(rv, STATUS_RESET); // RESET
		wr(REG_CORE_CTRL, 16'hFFFF);
		stack_frame_in <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(REG_CORE_CTRL);
		chk(rv, CORE_CTRL_WMASK | 16'h0004);
		chk(frame_unpaged_q, 1'b1);
		stack_frame_in <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk(frame_unpaged_q, 1'b0);
		$display("test registers done");
		wr(REG_CORE_CTRL, 16'h0000);
		for (n = 0; n < 40; n++) begin
			ra = $random(seed);
			rb = $random(seed);
			if (n < 2) ra = n[0] ? 16'h8000 : 16'hFFFF;
			if (n < 2) rb = 16'h0001;
			op_byte <= n[1];
			issue(n[0] ? OP_SUB : OP_ADD, ra, rb);
			e32 = alu_f(n[0], n[1], ra, rb);
			chk(res_valid_q, 1'b1);
			chk(res_lo_q, e32[15:0]);
			chk(status_word_q & 16'h010F, e32[31:16]);
		end
		for (n = 0; n < 12; n++) begin
			ra = $random(seed);
			rb = $random(seed);
			if (n == 2) rb = ra;
			op_byte <= (n >= 6);
			issue(cad_op_type'(5'(OP_AND + n % 6)), ra, rb);
			e32 = lgc_f(n % 6, n >= 6, ra, rb);
			chk(res_lo_q, e32[15:0]);
			chk(status_word_q & 16'h000A, e32[31:16]);
		end
		op_byte <= 1'b0;
		op_dest_mem <= 1'b1;
		issue(OP_ADD, 16'h1234, 16'h1111);
		op_dest_mem <= 1'b0;
		@(posedge ref_clk);
		#1 chk(u_cad_regfile.mem_q, 16'h2345);
		$display("test alu done");
		for (n = 0; n < 21; n++) begin
			c = cad_op_type'(5'(OP_MUL_SS + n % 7));
			ra = $random(seed);
			rb = $random(seed);
			if (n < 7) ra[15] = 1'b1;
			op_dest_idx <= ra[7:4];
			issue(c, ra, rb);
			e32 = mul_f(c, ra, rb);
			chk(res_lo_q, e32[15:0]);
			if (c == OP_MUL_BYTE) chk(res_hi_valid_q, 1'b0);
			else chk(res_hi_q, e32[31:16]);
			@(posedge ref_clk);
			#1 chk(u_cad_regfile.wreg_q[ra[7:4]], e32[15:0]);
		end
		$display("test multiply done");
		for (n = 0; n < 6; n++) begin
			ra = $random(seed);
			rb = $random(seed);
			rb[1:0] = 2'h2;
			rb[15] = ~n[0];
			oc = (n == 4) ? 16'h0000 : {1'b0, ra[14:0]};
			if (n[0]) begin
				eq = $signed(ra) / $signed(rb);
				er = $signed(ra) % $signed(rb);
			end else begin
				e32 = {oc, ra} / {16'h0000, rb};
				eq = e32[15:0];
				e32 = {oc, ra} % {16'h0000, rb};
				er = e32[15:0];
			end
			op_c <= oc;
			op_long <= ~n[0] && n != 4;
			issue(n[0] ? OP_DIV_S : OP_DIV_U, ra, rb);
			chk(op_ready_q, 1'b0);
			for (k = 1; k < 40 && res_valid_q !== 1'b1; k++) begin
				op_valid <= (k == 3);
				@(posedge ref_clk);
				#1;
			end
			if (k >= 40) begin
				bad_count++;
				tally_and_finish;
			end
			chk(k, 17);
			chk({res_lo_idx_q, res_hi_idx_q}, 8'h01);
			chk({res_lo_q, res_hi_q}, {eq, er});
			@(posedge ref_clk);
			#1 chk(res_valid_q, 1'b0);
			chk({u_cad_regfile.wreg_q[0], u_cad_regfile.wreg_q[1]}, {eq, er});
		end
		$display("test divide done");
		op_acc_b <= 1'b1;
		wr(REG_CORE_CTRL, 16'h0081);
		for (n = 0; n < 8; n++) begin
			ra = $random(seed);
			rb = $random(seed);
			if (n == 4) wr(REG_CORE_CTRL, 16'h0080);
			p = prod(ra, rb, n >= 4);
			case (n % 4)
				0: c = MULTIPLY_ONLY_OP;
				1: c = MULTIPLY_ACCUM_OP;
				2: c = MULTIPLY_SUBTRACT_OP;
				default: c = NEGATED_MULTIPLY_OP;
			endcase
			eb = (n % 4 == 0) ? p : (n % 4 == 1) ? eb + p : (n % 4 == 2) ? eb - p : -p;
			issue(c, ra, rb);
			rdacc(1'b1);
			chk(acc, eb);
		end
		op_acc_b <= 1'b0;
		wr(REG_CORE_CTRL, 16'h0001);
		ra = 16'h0010 + 16'($random(seed) & 16'h00FF);
		rb = 16'h0010 + 16'($random(seed) & 16'h00FF);
		e = prod(ra - rb, ra - rb, 1'b0);
		issue(SQUARE_OF_DIFF_OP, ra, rb);
		issue(ACCUM_SQUARE_OF_DIFF_OP, ra, rb);
		rdacc(1'b0);
		chk(acc, e + e);
		issue(OP_ACC_ADD, 16'h0000, 16'h0000);
		issue(OP_ACC_NEG, 16'h0000, 16'h0000);
		rdacc(1'b0);
		chk(acc, -(e + e + eb));
		wr(REG_CORE_CTRL, 16'h0081);
		for (n = 0; n < 2; n++) begin
			op_acc_b <= n[0];
			issue(ACCUMULATOR_ZERO_OP, 16'h0000, 16'h0000);
			repeat (3) issue(MULTIPLY_ACCUM_OP, 16'h7FFF, 16'h7FFF);
			rdacc(n[0]);
			chk(acc, n[0] ? 40'h00BFFD0003 : ACC_MAX_NORM);
		end
		op_acc_b <= 1'b0;
		for (n = 0; n < 2; n++) begin
			wr(REG_CORE_CTRL, n[0] ? 16'h0003 : 16'h0001);
			issue(MULTIPLY_ONLY_OP, 16'h0080, 16'h0100);
			issue(STORE_ACCUM_OP, 16'h0000, 16'h0000);
			chk({res_valid_q, res_lo_q}, {1'b1, 16'(n)});
			rdacc(1'b0);
			chk(acc, 40'h0000008000);
		end
		$display("test dsp done");
		tally_and_finish;
	end
endmodule
